//--- core/ssc_pkg.sv
// ****************************************************************
// endpoint companion descriptor constants
// ****************************************************************
package ssc_pkg;

  // endpoint selector codes on the request port
  localparam logic [1:0] EP_BULK_IN = 2'h0;
  localparam logic [1:0] EP_BULK_OUT = 2'h1;
  localparam logic [1:0] EP_INTR = 2'h2;

  // byte offsets inside a companion descriptor
  localparam logic [2:0] OFS_LEN = 3'h0;
  localparam logic [2:0] OFS_TYPE = 3'h1;
  localparam logic [2:0] OFS_BURST = 3'h2;
  localparam logic [2:0] OFS_ATTR = 3'h3;
  localparam logic [2:0] OFS_BPI_LO = 3'h4;
  localparam logic [2:0] OFS_BPI_HI = 3'h5;

  // fixed descriptor content
  localparam logic [2:0] DESC_BYTES = 3'h6;
  localparam logic [7:0] DESC_LEN = 8'h06;
  localparam logic [7:0] DESC_TYPE = 8'h30;
  localparam logic [7:0] BULK_ATTR = 8'h00;
  localparam logic [15:0] BULK_BPI = 16'h0000;
  localparam logic [7:0] INTR_BURST = 8'h00;
  localparam logic [7:0] INTR_ATTR = 8'h00;
  localparam logic [15:0] INTR_BPI = 16'h0004;

  // burst encoding: packets minus one, 0 to 15
  localparam int BURST_W = 4;
  localparam logic [3:0] BURST_MAX = 4'hf;
  localparam logic [3:0] BURST_RST = 4'h3;

endpackage : ssc_pkg

//--- core/ssc_desc_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// carrier between sequencer, burst holder and byte lookup
// ****************************************************************
interface ssc_desc_if #(
  parameter int FIELD_W = 4
);
  logic [1:0] ep;
  logic [2:0] idx;
  logic capture;
  logic [FIELD_W-1:0] raw_in;
  logic [FIELD_W-1:0] raw_out;
  logic [3:0] burst_in;
  logic [3:0] burst_out;
  logic [7:0] byte_val;

  modport seq (output ep, idx, capture, raw_in, raw_out,
               input burst_in, burst_out, byte_val);
  modport burst (input capture, raw_in, raw_out,
                 output burst_in, burst_out);
  modport rom (input ep, idx, burst_in, burst_out,
               output byte_val);
endinterface : ssc_desc_if
`default_nettype wire

//--- core/ssc_burst_hold.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// burst limit holder: samples config fields per request, clamps
// ****************************************************************
module ssc_burst_hold
  import ssc_pkg::*;
#(
  parameter int FIELD_W = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  ssc_desc_if.burst bif
);

  typedef struct packed {
    logic [3:0] burst_in;
    logic [3:0] burst_out;
  } ssc_hold_t;

  ssc_hold_t s_q;
  ssc_hold_t s_d;

  // limit a field to the legal 0..15 burst range
  function automatic logic [3:0] clamp_burst(
    input logic [FIELD_W-1:0] v
  );
    logic [FIELD_W+3:0] wide;
    wide = {4'h0, v};
    if (wide > (FIELD_W+4)'(BURST_MAX)) begin
      return BURST_MAX;
    end
    return wide[3:0];
  endfunction : clamp_burst

  // fields are frozen at request time so a transfer sees one value
  always_comb begin
    s_d = s_q;
    if (bif.capture) begin
      s_d.burst_in = clamp_burst(bif.raw_in);
      s_d.burst_out = clamp_burst(bif.raw_out);
    end
  end

  // defaults match the register reset value
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_q <= '{burst_in: BURST_RST, burst_out: BURST_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign bif.burst_in = s_q.burst_in;
  assign bif.burst_out = s_q.burst_out;

endmodule : ssc_burst_hold
`default_nettype wire

//--- core/ssc_desc_rom.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// byte lookup for the three companion descriptors
// ****************************************************************
module ssc_desc_rom
  import ssc_pkg::*;
(
  ssc_desc_if.rom rif
);

  // pick one byte of one descriptor; wide fields go low byte first
  function automatic logic [7:0] desc_byte(
    input logic [1:0] ep,
    input logic [2:0] idx,
    input logic [3:0] bin,
    input logic [3:0] bout
  );
    logic bulk;
    bulk = (ep != EP_INTR);
    case (idx)
      OFS_LEN: return DESC_LEN;
      OFS_TYPE: return DESC_TYPE;
      OFS_BURST: begin
        if (ep == EP_BULK_IN) begin
          return {4'h0, bin};
        end else if (ep == EP_BULK_OUT) begin
          return {4'h0, bout};
        end
        return INTR_BURST;
      end
      OFS_ATTR: return bulk ? BULK_ATTR : INTR_ATTR;
      OFS_BPI_LO: return bulk ? BULK_BPI[7:0] : INTR_BPI[7:0];
      OFS_BPI_HI: return bulk ? BULK_BPI[15:8] : INTR_BPI[15:8];
      default: return 8'h00;
    endcase
  endfunction : desc_byte

  // content is built only from constants and burst fields
  always_comb begin
    rif.byte_val = desc_byte(rif.ep, rif.idx, rif.burst_in,
                             rif.burst_out);
  end

endmodule : ssc_desc_rom
`default_nettype wire

//--- core/ssc_desc_gen.sv
// What this block does
// - descriptors come only from fixed values and config fields, never OTP
// - each descriptor is six bytes, length 06h, type 30h
// - bulk-in burst byte follows the bulk-in burst limit field
// - bulk-out burst byte follows the bulk-out burst limit field
// - burst values are packets minus one, limited to 0 through 15
// - bulk attributes byte is 00h, bulk type without streams
// - bulk bytes-per-interval returns 0000h
// - interrupt burst byte is 00h, one packet per burst
// - interrupt attributes byte is zero
// - interrupt bytes-per-interval returns 0004h
`timescale 1ns/1ps
`default_nettype none
module ssc_desc_gen
  import ssc_pkg::*;
#(
  parameter int FIELD_W = BURST_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_ep,
  input wire logic [15:0] i_req_length,
  input wire logic [FIELD_W-1:0] i_bulk_in_burst_limit,
  input wire logic [FIELD_W-1:0] i_bulk_out_burst_limit,
  input wire logic i_data_ready,
  output logic o_busy,
  output logic o_data_valid,
  output logic [7:0] o_data,
  output logic o_data_last,
  output logic o_done,
  output logic o_stall
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SEND
  } ssc_fsm_t;

  typedef struct packed {
    ssc_fsm_t fsm;
    logic [1:0] ep;
    logic [2:0] idx;
    logic [2:0] cnt;
    logic busy;
    logic valid;
    logic [7:0] data;
    logic last;
    logic done;
    logic stall;
  } ssc_state_t;

  localparam ssc_state_t S_RST = '{fsm: ST_IDLE, default: '0};

  ssc_state_t s_q;
  ssc_state_t s_d;

  ssc_desc_if #(.FIELD_W(FIELD_W)) dif ();

  // ****************************************************************
  // helpers
  // ****************************************************************

  // bytes to send: requested length, never more than the descriptor
  function automatic logic [2:0] reply_count(input logic [15:0] len);
    if (len < {13'h0, DESC_BYTES}) begin
      return len[2:0];
    end
    return DESC_BYTES;
  endfunction : reply_count

  logic req_ep_ok;
  logic req_take;

  // only the three companion endpoints are served
  assign req_ep_ok = (i_req_ep == EP_BULK_IN) ||
                     (i_req_ep == EP_BULK_OUT) ||
                     (i_req_ep == EP_INTR);
  assign req_take = (s_q.fsm == ST_IDLE) && i_req_valid && req_ep_ok &&
                    (i_req_length != 16'h0000);

  // ****************************************************************
  // submodules
  // ****************************************************************

  // sub-block inputs
  assign dif.ep = s_q.ep;
  assign dif.idx = s_q.idx;
  assign dif.capture = req_take;
  assign dif.raw_in = i_bulk_in_burst_limit;
  assign dif.raw_out = i_bulk_out_burst_limit;

  ssc_burst_hold #(
    .FIELD_W(FIELD_W)
  ) u_burst (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .bif(dif)
  );

  ssc_desc_rom u_rom (
    .rif(dif)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // idle -> load byte -> hold until accepted, repeat to the cut length
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.stall = 1'b0;
    case (s_q.fsm)
      ST_IDLE: begin
        if (i_req_valid) begin
          if (!req_ep_ok) begin
            s_d.stall = 1'b1; // unknown endpoint
          end else if (i_req_length == 16'h0000) begin
            s_d.done = 1'b1; // zero-length data stage
          end else begin
            s_d.ep = i_req_ep;
            s_d.idx = OFS_LEN;
            s_d.cnt = reply_count(i_req_length);
            s_d.fsm = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        s_d.data = dif.byte_val;
        s_d.valid = 1'b1;
        s_d.last = (s_q.idx == s_q.cnt - 3'h1);
        s_d.fsm = ST_SEND;
      end
      ST_SEND: begin
        if (i_data_ready) begin
          s_d.valid = 1'b0;
          s_d.last = 1'b0;
          if (s_q.last) begin
            s_d.done = 1'b1;
            s_d.fsm = ST_IDLE;
          end else begin
            s_d.idx = s_q.idx + 3'h1; // low byte before high byte
            s_d.fsm = ST_LOAD;
          end
        end
      end
      default: begin
        s_d = S_RST;
      end
    endcase
    s_d.busy = (s_d.fsm != ST_IDLE);
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign o_busy = s_q.busy;
  assign o_data_valid = s_q.valid;
  assign o_data = s_q.data;
  assign o_data_last = s_q.last;
  assign o_done = s_q.done;
  assign o_stall = s_q.stall;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic [3:0] burst_in_seen;
  logic [3:0] burst_out_seen;
  logic is_bulk;

  assign burst_in_seen = dif.burst_in;
  assign burst_out_seen = dif.burst_out;
  assign is_bulk = (s_q.ep == EP_BULK_IN) || (s_q.ep == EP_BULK_OUT);

  logic zero_take;
  logic len_short;
  logic [2:0] len_lo;
  logic [3:0] in_lo;
  logic [3:0] out_lo;
  logic in_over;
  logic out_over;

  // request facts worked out apart from the sequencer and burst holder
  assign zero_take = (s_q.fsm == ST_IDLE) && i_req_valid && req_ep_ok &&
                     (i_req_length == 16'h0000);
  assign len_short = (i_req_length < {13'h0, DESC_BYTES});
  assign len_lo = i_req_length[2:0];
  assign in_lo = i_bulk_in_burst_limit[3:0];
  assign out_lo = i_bulk_out_burst_limit[3:0];
  assign in_over = (i_bulk_in_burst_limit > FIELD_W'(BURST_MAX));
  assign out_over = (i_bulk_out_burst_limit > FIELD_W'(BURST_MAX));

  sequence s_accept;
    req_take;
  endsequence

  sequence s_first_byte;
    ##2 (o_data_valid && o_data == DESC_LEN && o_busy);
  endsequence

  sequence s_wait_byte;
    o_data_valid && !i_data_ready;
  endsequence

  sequence s_hold_byte;
    ##1 (o_data_valid && $stable(o_data) && $stable(o_data_last));
  endsequence

  desc_head_a: assert property (
    s_accept |-> s_first_byte
  ) else $error("first byte is not the length 06h");

  desc_type_a: assert property (
    o_data_valid && s_q.idx == OFS_TYPE |-> o_data == 8'h30
  ) else $error("type byte is not 30h");

  bulk_in_burst_a: assert property (
    o_data_valid && s_q.idx == OFS_BURST && s_q.ep == EP_BULK_IN
      |-> o_data == {4'h0, burst_in_seen}
  ) else $error("bulk-in burst byte differs from field");

  bulk_out_burst_a: assert property (
    o_data_valid && s_q.idx == OFS_BURST && s_q.ep == EP_BULK_OUT
      |-> o_data == {4'h0, burst_out_seen}
  ) else $error("bulk-out burst byte differs from field");

  burst_range_a: assert property (
    o_data_valid && s_q.idx == OFS_BURST |-> o_data <= 8'h0f
  ) else $error("burst byte above 15");

  bulk_attr_a: assert property (
    o_data_valid && is_bulk && s_q.idx == OFS_ATTR |-> o_data == 8'h00
  ) else $error("bulk attributes not zero");

  bulk_interval_a: assert property (
    o_data_valid && is_bulk && s_q.idx >= OFS_BPI_LO |-> o_data == 8'h00
  ) else $error("bulk bytes-per-interval not zero");

  intr_burst_a: assert property (
    o_data_valid && s_q.ep == EP_INTR && s_q.idx == OFS_BURST
      |-> o_data == 8'h00
  ) else $error("interrupt burst not zero");

  intr_attr_a: assert property (
    o_data_valid && s_q.ep == EP_INTR && s_q.idx == OFS_ATTR
      |-> o_data == 8'h00
  ) else $error("interrupt attributes not zero");

  intr_interval_a: assert property (
    o_data_valid && s_q.ep == EP_INTR && s_q.idx == OFS_BPI_LO
      |-> o_data == 8'h04
  ) else $error("interrupt bytes-per-interval low byte not 04h");

  intr_interval_hi_a: assert property (
    o_data_valid && s_q.ep == EP_INTR && s_q.idx == OFS_BPI_HI
      |-> o_data == 8'h00
  ) else $error("interrupt bytes-per-interval high byte not 00h");

  reply_cut_a: assert property (
    s_accept |=> s_q.cnt == ($past(len_short) ? $past(len_lo) : DESC_BYTES)
  ) else $error("reply count is not the cut length");

  last_byte_a: assert property (
    o_data_valid && o_data_last |-> s_q.idx == s_q.cnt - 3'h1
  ) else $error("last flag on wrong byte");

  byte_hold_a: assert property (
    s_wait_byte |-> s_hold_byte
  ) else $error("byte changed while stalled");

  done_pulse_a: assert property (
    o_data_valid && o_data_last && i_data_ready
      |=> o_done && !o_busy ##1 (!o_done || $past(zero_take))
  ) else $error("done does not follow the last byte");

  zero_len_a: assert property (
    zero_take |=> o_done && !o_busy && !o_data_valid
  ) else $error("zero-length request did not end at once");

  burst_frozen_a: assert property (
    o_busy |=> $stable(burst_in_seen) && $stable(burst_out_seen)
  ) else $error("burst field moved during a reply");

  bulk_in_field_a: assert property (
    req_take |=> burst_in_seen == ($past(in_over) ? BURST_MAX : $past(in_lo))
  ) else $error("bulk-in burst not taken from its field");

  bulk_out_field_a: assert property (
    req_take
      |=> burst_out_seen == ($past(out_over) ? BURST_MAX : $past(out_lo))
  ) else $error("bulk-out burst not taken from its field");

endmodule : ssc_desc_gen
`default_nettype wire

//--- testbench/ssc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host side consumer of descriptor bytes
// ****************************************************************
module ssc_host_model (
  input wire logic i_core_clk,
  input wire logic i_slow,
  output logic o_data_ready = 1'b0
);
  logic [31:0] lfsr_q = 32'h9267;

  // accepts every byte when prompt, stalls at random when slow
  always @(posedge i_core_clk) begin
    lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    o_data_ready <= #1 !i_slow || lfsr_q[0];
  end
endmodule : ssc_host_model
`default_nettype wire

//--- testbench/ss_endpoint_companion_descriptors_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// descriptor generator bench
// ****************************************************************
module ss_endpoint_companion_descriptors_tb_top;
  import ssc_pkg::*;
  logic clk, rst_n, req_valid, ready, slow;
  logic busy, dvalid, last, done, stall;
  logic [1:0] req_ep;
  logic [15:0] req_len;
  logic [3:0] bin, bout;
  logic [7:0] data;
  logic [31:0] seed;
  logic [10:0] expq[$];
  logic [15:0] lens[6] = '{16'h0000, 16'h0001, 16'h0004, 16'h0005,
                          16'h0007, 16'hffff};
  int n_errors = 0;
  int checked = 0;

  ssc_desc_gen #(.FIELD_W(4)) uut (
    .i_core_clk(clk),
    .i_rst_n(rst_n),
    .i_req_valid(req_valid),
    .i_req_ep(req_ep),
    .i_req_length(req_len),
    .i_bulk_in_burst_limit(bin),
    .i_bulk_out_burst_limit(bout),
    .i_data_ready(ready),
    .o_busy(busy),
    .o_data_valid(dvalid),
    .o_data(data),
    .o_data_last(last),
    .o_done(done),
    .o_stall(stall)
  );

  ssc_host_model host (
    .i_core_clk(clk),
    .i_slow(slow),
    .o_data_ready(ready)
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // compares one value and counts it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // prints counts and verdict, ends the run
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // issues one request, notes the reply, waits for its end
  task automatic req(input logic [1:0] ep, input logic [15:0] len,
                     input logic [3:0] bi, input logic [3:0] bo,
                     input logic poke);
    logic [7:0] b[6];
    int n;
    int k;
    b[0] = 8'h06;
    b[1] = 8'h30;
    b[2] = (ep == 2'h0) ? {4'h0, bi} : 8'h00;
    if (ep == 2'h1) b[2] = {4'h0, bo};
    b[3] = 8'h00;
    {b[5], b[4]} = (ep == 2'h2) ? 16'h0004 : 16'h0000;
    n = (len < 16'd6) ? int'(len) : 6;
    if (ep == 2'h3) begin
      expq.push_back(11'h400);
    end else begin
      for (int i = 0; i < n; i++) begin
        expq.push_back({2'b00, i == n - 1, b[i]});
      end
      expq.push_back(11'h200);
    end
    req_valid = 1'b1;
    req_ep = ep;
    req_len = len;
    bin = bi;
    bout = bo;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    seed = lfsr(seed);
    bin = seed[3:0]; // fields move, reply keeps the sampled ones
    bout = seed[7:4];
    if (ep != 2'h3 && len != 16'h0) chk(16'(busy), 16'h1);
    if (poke) begin
      repeat (2) @(posedge clk);
      #1;
      req_valid = 1'b1; // must be ignored while busy
      req_ep = 2'h3;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
    end
    k = 0;
    while (done !== 1'b1 && stall !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 300) chk(16'h0, 16'h1);
    // let an edge pass so the next strobe is not set in this time step
    if (k == 0) begin
      @(posedge clk);
      #1;
    end
  endtask : req

  // takes the oldest note whenever a byte is accepted or a pulse appears
  always @(negedge clk) begin
    if (rst_n === 1'b1 && (dvalid && ready || done || stall)) begin
      if (expq.size() == 0) chk(16'({stall, done, last, data}), 16'hffff);
      else if (dvalid && ready) chk(16'({last, data}),
                                    16'(expq.pop_front()));
      else chk(16'({stall, done, 9'h0}), 16'(expq.pop_front()));
    end
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_ep = 2'h0;
    req_len = 16'h0;
    bin = 4'h0;
    bout = 4'h0;
    slow = 1'b0;
    seed = 32'h9267;
    repeat (4) @(posedge clk);
    #1;
    chk(16'({busy, dvalid, last, done, stall}), 16'h0);
    rst_n = 1'b1;
    for (int e = 0; e < 4; e++) begin
      req(e[1:0], 16'd6, 4'h0, 4'hf, 1'b0);
      req(e[1:0], 16'd6, 4'hf, 4'h0, 1'b0);
    end
    foreach (lens[i]) req(2'h2, lens[i], 4'h3, 4'h3, 1'b0);
    req(2'h0, 16'd6, 4'h5, 4'ha, 1'b1);
    slow = 1'b1;
    repeat (40) begin
      seed = lfsr(seed);
      req(seed[1:0], {13'h0, seed[6:4]}, seed[11:8], seed[15:12], 1'b0);
    end
    repeat (2) @(posedge clk);
    chk(16'(expq.size()), 16'h0);
    results();
  end

  // cuts a hang short
  initial begin
    #(40 * 20000);
    n_errors++;
    results();
  end
endmodule : ss_endpoint_companion_descriptors_tb_top
`default_nettype wire
